// ==== hw/msad_pkg.sv ====
// Package of address map constants for the memory space decode block.
`default_nettype none
package msad_pkg;
  localparam int PADDR_W = 24;
  localparam int PC_W = 23;
  localparam int DADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [23:0] RESET_ADDR = 24'h00_0000;
  localparam logic [23:0] GOTO_TARGET_ADDR = 24'h00_0002;
  localparam logic [23:0] USER_TOP = 24'h7F_FFFF;
  localparam logic [23:0] IVT_START = 24'h00_0004;
  localparam logic [23:0] IVT_END = 24'h00_00FF;
  localparam logic [23:0] ALT_IVT_START = 24'h00_0100;
  localparam logic [23:0] ALT_IVT_END = 24'h00_01FF;
  localparam logic [23:0] VECTOR_LIMIT = 24'h00_0200;
  localparam logic [15:0] SFR_TOP = 16'h07FF;
  localparam logic [15:0] DATA_IMPL_BYTES = 16'h7800;
  localparam int WINDOW_SEL_BIT = 15;
  localparam int TABLE_PAGE_TOP_BIT = 7;
  localparam logic [22:0] PC_STEP = 23'h00_0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  typedef enum logic [1:0] {
    MSAD_EXT_NONE = 2'b00,
    MSAD_EXT_SIGN = 2'b01,
    MSAD_EXT_ZERO = 2'b11
  } msad_ext_type;
endpackage
`default_nettype wire

// ==== hw/msad_data_if.sv ====
// Interface carrying one data space access between decode and lane logic.
`default_nettype none
interface msad_data_if;
  logic [15:0] addr;
  logic is_byte;
  logic [15:0] wdata;
  logic [15:0] word_rdata;
  logic [15:0] lane_rdata;
  logic [1:0] lane_we;
  modport decode (output addr, output is_byte, output wdata,
    input lane_rdata, input lane_we, output word_rdata);
  modport lane (input addr, input is_byte, input wdata, input word_rdata,
    output lane_rdata, output lane_we);
endinterface
`default_nettype wire

// ==== hw/msad_byte_lane.sv ====
// Byte lane steering for data space reads and writes.
`default_nettype none
module msad_byte_lane (
  msad_data_if.lane bus
);
  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  // A byte read picks the lane by address bit zero, delivered low.
  wire logic odd_byte = bus.addr[0];
  assign bus.lane_rdata = bus.is_byte ?
    {8'h00, (odd_byte ? bus.word_rdata[15:8] : bus.word_rdata[7:0])} :
    bus.word_rdata;
  // Byte writes strobe only the matching lane; words strobe both.
  assign bus.lane_we = bus.is_byte ? {odd_byte, ~odd_byte} : 2'b11;
endmodule
`default_nettype wire

// ==== hw/msad_prog_addr.sv ====
// Program counter and program address formation.
`default_nettype none
module msad_prog_addr (
  input wire logic clk,
  input wire logic rst,
  input wire logic step_fwd,
  input wire logic step_back,
  input wire logic load_pc,
  input wire logic [22:0] load_value,
  output logic [22:0] pc_q
);
  logic [22:0] pc_reg;
  logic [22:0] pc_next;
  // ----------------------------------------------------------------
  // Counter update
  // ----------------------------------------------------------------
  // Loads keep bit zero clear so fetches stay on the lower word.
  always_comb begin
    pc_next = pc_reg;
    if (load_pc) begin
      pc_next = {load_value[22:1], 1'b0};
    end else if (step_fwd) begin
      pc_next = pc_reg + msad_pkg::PC_STEP;
    end else if (step_back) begin
      pc_next = pc_reg - msad_pkg::PC_STEP;
    end
  end
  // Reset starts fetching at the reset vector.
  always_ff @(posedge clk) begin
    if (rst) pc_reg <= msad_pkg::RESET_ADDR[22:0];
    else pc_reg <= pc_next;
  end
  assign pc_q = pc_reg;
endmodule
`default_nettype wire

// ==== hw/msad_top.sv ====
// Address space decode and access logic for program and data spaces.
`default_nettype none
// Operation
// - Program address is 24 bits, from 23-bit counter or table paths.
// - User program access limited to lower half; table ops use page bit.
// - Program location is even lower word plus odd upper word.
// - Counter program addresses stay word-aligned, counter steps by two.
// - Fetch starts at zero after reset; software puts a jump there.
// - Region below 0x200 reserved for reset and two vector tables.
// - Separate read and write address generators for data space.
// - Data effective addresses are 16-bit byte addresses.
// - Bit 15 clear maps to memory, set maps to program window.
// - Reads beyond implemented 30 Kbytes return zero.
// - Low byte at even address, high byte at odd address.
// - Post-increment adds one for bytes, two for words.
// - Byte read selects lane by bit zero, delivers on low lane.
// - Shared word decode, separate byte write strobes.
// - Misaligned word access raises trap after instruction completes.
// - Misaligned read completes; misaligned write is suppressed.
// - Byte load changes only the working register low byte.
// - Sign-extend widens byte to word; zero-extend clears high byte.
// - Low 2 Kbytes are function registers; unused ones read zero.
module msad_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic pc_step_fwd,
  input wire logic pc_step_back,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_value,
  input wire logic table_op,
  input wire logic [7:0] table_page_pointer,
  input wire logic [15:0] table_offset,
  output logic [23:0] prog_addr,
  output logic prog_upper_word,
  output logic prog_in_vectors,
  output logic prog_access_fault,
  input wire logic rd_en,
  input wire logic [15:0] rd_effective_address,
  input wire logic rd_is_byte,
  input wire logic [15:0] rd_mem_word,
  input wire logic rd_sfr_hit,
  output logic [15:0] rd_data,
  output logic rd_program_window_view,
  output logic [15:0] rd_ptr_incr,
  input wire logic wr_en,
  input wire logic [15:0] wr_effective_address,
  input wire logic wr_is_byte,
  input wire logic [15:0] wr_data,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_byte_we,
  output logic [15:0] wr_ptr_incr,
  input wire logic instr_done,
  output logic address_error_trap,
  input wire logic [15:0] wreg_value,
  input wire logic [1:0] ext_op,
  output logic [15:0] wreg_result
);
  // ----------------------------------------------------------------
  // Program side
  // ----------------------------------------------------------------
  logic [22:0] pc_q;
  msad_prog_addr u_pc (
    .clk(clk),
    .rst(rst),
    .step_fwd(pc_step_fwd),
    .step_back(pc_step_back),
    .load_pc(pc_load),
    .load_value(pc_load_value),
    .pc_q(pc_q)
  );
  // Table ops reach configuration space through the page top bit.
  wire logic [23:0] table_addr = {table_page_pointer, table_offset};
  wire logic [23:0] exec_addr = {1'b0, pc_q};
  wire logic [23:0] paddr_next = table_op ? table_addr : exec_addr;
  wire logic user_fault = ~table_op & (exec_addr > msad_pkg::USER_TOP);
  wire logic vec_next = paddr_next < msad_pkg::VECTOR_LIMIT;
  logic [23:0] prog_addr_reg;
  logic prog_upper_reg;
  logic prog_vec_reg;
  logic prog_fault_reg;
  // Odd program address names the upper word of a location.
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_addr_reg <= msad_pkg::RESET_ADDR;
      prog_upper_reg <= 1'b0;
      prog_vec_reg <= 1'b1;
      prog_fault_reg <= 1'b0;
    end else begin
      prog_addr_reg <= paddr_next;
      prog_upper_reg <= paddr_next[0];
      prog_vec_reg <= vec_next;
      prog_fault_reg <= user_fault;
    end
  end
  // Program side outputs come straight from their registers.
  assign prog_addr = prog_addr_reg;
  assign prog_upper_word = prog_upper_reg;
  assign prog_in_vectors = prog_vec_reg;
  assign prog_access_fault = prog_fault_reg;

  // ----------------------------------------------------------------
  // Read address generator
  // ----------------------------------------------------------------
  msad_data_if rd_if ();
  msad_byte_lane u_rd_lane (.bus(rd_if.lane));
  // The read generator has its own decode, never shared with writes.
  wire logic rd_window =
    rd_effective_address[msad_pkg::WINDOW_SEL_BIT];
  wire logic rd_in_sfr = rd_effective_address <= msad_pkg::SFR_TOP;
  wire logic rd_impl = ~rd_window &
    (rd_effective_address < msad_pkg::DATA_IMPL_BYTES);
  // Unused function register space reads as zero as well.
  wire logic rd_valid = rd_impl & (~rd_in_sfr | rd_sfr_hit);
  assign rd_if.addr = rd_effective_address;
  assign rd_if.is_byte = rd_is_byte;
  assign rd_if.wdata = msad_pkg::ZERO_WORD;
  assign rd_if.word_rdata = rd_valid ? rd_mem_word : msad_pkg::ZERO_WORD;
  // Only a word access at an odd address counts as misaligned.
  wire logic rd_misalign = rd_en & ~rd_is_byte & rd_effective_address[0];
  wire logic [15:0] rd_incr_next = rd_is_byte ? msad_pkg::BYTE_STEP :
    msad_pkg::WORD_STEP;
  logic [15:0] rd_data_reg;
  logic rd_window_reg;
  logic [15:0] rd_incr_reg;
  // A misaligned read still completes and returns its data.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= msad_pkg::ZERO_WORD;
      rd_window_reg <= 1'b0;
      rd_incr_reg <= msad_pkg::ZERO_WORD;
    end else if (rd_en) begin
      rd_data_reg <= rd_if.lane_rdata;
      rd_window_reg <= rd_window;
      rd_incr_reg <= rd_incr_next;
    end
  end
  // Read results stand until the next read request.
  assign rd_data = rd_data_reg;
  assign rd_program_window_view = rd_window_reg;
  assign rd_ptr_incr = rd_incr_reg;

  // ----------------------------------------------------------------
  // Write address generator
  // ----------------------------------------------------------------
  msad_data_if wr_if ();
  msad_byte_lane u_wr_lane (.bus(wr_if.lane));
  // The write generator decodes its own address and data.
  assign wr_if.addr = wr_effective_address;
  assign wr_if.is_byte = wr_is_byte;
  assign wr_if.wdata = wr_data;
  assign wr_if.word_rdata = msad_pkg::ZERO_WORD;
  wire logic wr_misalign = wr_en & ~wr_is_byte & wr_effective_address[0];
  // Byte data is replicated so either strobed lane sees it.
  wire logic [15:0] wr_lanes = wr_is_byte ? {wr_data[7:0], wr_data[7:0]} :
    wr_data;
  wire logic [1:0] we_next = (wr_en & ~wr_misalign) ?
    wr_if.lane_we : 2'b00;
  logic [15:0] mem_addr_reg;
  logic [15:0] mem_wdata_reg;
  logic [1:0] mem_we_reg;
  logic [15:0] wr_incr_reg;
  // Write strobes are registered from each cycle's request; the word address drops bit 0.
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr_reg <= msad_pkg::ZERO_WORD;
      mem_wdata_reg <= msad_pkg::ZERO_WORD;
      mem_we_reg <= 2'b00;
      wr_incr_reg <= msad_pkg::ZERO_WORD;
    end else begin
      mem_we_reg <= we_next;
      if (wr_en) begin
        mem_addr_reg <= {wr_effective_address[15:1], 1'b0};
        mem_wdata_reg <= wr_lanes;
        wr_incr_reg <= wr_is_byte ? msad_pkg::BYTE_STEP :
          msad_pkg::WORD_STEP;
      end
    end
  end
  // Memory side outputs come straight from their registers.
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_byte_we = mem_we_reg;
  assign wr_ptr_incr = wr_incr_reg;

  // ----------------------------------------------------------------
  // Address error trap
  // ----------------------------------------------------------------
  // The fault is held pending so the trap fires once the instruction
  // ends; a new fault in the completing cycle is still reported.
  logic pend_reg;
  logic trap_reg;
  wire logic fault_now = rd_misalign | wr_misalign;
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else begin
      trap_reg <= instr_done & (pend_reg | fault_now);
      pend_reg <= ~instr_done & (pend_reg | fault_now);
    end
  end
  assign address_error_trap = trap_reg;

  // ----------------------------------------------------------------
  // Working register byte handling
  // ----------------------------------------------------------------
  logic [15:0] wres_next;
  // Extend ops act on the register; a byte load keeps the high byte.
  always_comb begin
    case (ext_op)
      msad_pkg::MSAD_EXT_SIGN: wres_next =
        {{8{wreg_value[7]}}, wreg_value[7:0]};
      msad_pkg::MSAD_EXT_ZERO: wres_next = {8'h00, wreg_value[7:0]};
      default: wres_next = (rd_en & rd_is_byte) ?
        {wreg_value[15:8], rd_if.lane_rdata[7:0]} :
        (rd_en ? rd_if.lane_rdata : wreg_value);
    endcase
  end
  logic [15:0] wres_reg;
  always_ff @(posedge clk) begin
    if (rst) wres_reg <= msad_pkg::ZERO_WORD;
    else wres_reg <= wres_next;
  end
  assign wreg_result = wres_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Assertions are idle in reset; each names the rule that it guards.
  a_write_suppress: assert property (@(posedge clk) disable iff (rst)
    wr_en & ~wr_is_byte & wr_effective_address[0] |=> mem_byte_we == 2'b00)
    else $error("misaligned write not suppressed");
  a_byte_strobe: assert property (@(posedge clk) disable iff (rst)
    wr_en & wr_is_byte |=> $onehot(mem_byte_we))
    else $error("byte write strobes wrong lanes");
  a_trap_after: assert property (@(posedge clk) disable iff (rst)
    rd_misalign & instr_done |=> address_error_trap)
    else $error("trap not raised after fault");
  a_byte_no_trap: assert property (@(posedge clk) disable iff (rst)
    ~pend_reg & ~(rd_en & ~rd_is_byte) & ~(wr_en & ~wr_is_byte)
    |=> ~address_error_trap)
    else $error("trap without word misalignment");
  a_window_zero: assert property (@(posedge clk) disable iff (rst)
    rd_en & rd_effective_address[15] |=> rd_data == 16'h0000)
    else $error("window read not zero");
  a_pc_even: assert property (@(posedge clk) disable iff (rst)
    ~table_op |=> ~prog_addr[0])
    else $error("program address not aligned");
  a_pc_step: assert property (@(posedge clk) disable iff (rst)
    pc_step_fwd & ~pc_load & ~table_op ##1 ~table_op |=>
    prog_addr[22:0] == $past(prog_addr[22:0]) + 23'h00_0002)
    else $error("counter did not step by two");
  a_incr_size: assert property (@(posedge clk) disable iff (rst)
    rd_en |=> rd_ptr_incr == ($past(rd_is_byte) ? 16'h0001 : 16'h0002))
    else $error("pointer step wrong");
  a_clear_high: assert property (@(posedge clk) disable iff (rst)
    ext_op == 2'b11 |=> wreg_result[15:8] == 8'h00)
    else $error("zero extend left high byte");
  a_reset_fetch: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> prog_addr == 24'h00_0000 && prog_in_vectors)
    else $error("fetch does not restart at zero");
  a_oor_zero: assert property (@(posedge clk) disable iff (rst)
    rd_en & ~rd_effective_address[15] &
    (rd_effective_address >= msad_pkg::DATA_IMPL_BYTES)
    |=> rd_data == 16'h0000)
    else $error("read beyond memory not zero");
  a_hole_zero: assert property (@(posedge clk) disable iff (rst)
    rd_en & (rd_effective_address <= msad_pkg::SFR_TOP) & ~rd_sfr_hit
    |=> rd_data == 16'h0000)
    else $error("unused register space not zero");
  a_byte_low_lane: assert property (@(posedge clk) disable iff (rst)
    rd_en & rd_is_byte |=> rd_data[15:8] == 8'h00)
    else $error("byte read not on low lane");
  a_window_flag: assert property (@(posedge clk) disable iff (rst)
    rd_en |=> rd_program_window_view == $past(rd_effective_address[15]))
    else $error("window flag does not follow address bit");
  a_word_even: assert property (@(posedge clk) disable iff (rst)
    wr_en |=> ~mem_addr[0])
    else $error("write word address odd");
  a_byte_copy: assert property (@(posedge clk) disable iff (rst)
    wr_en & wr_is_byte |=> mem_wdata == {2{$past(wr_data[7:0])}})
    else $error("byte write data not on both lanes");
  a_no_early_trap: assert property (@(posedge clk) disable iff (rst)
    ~instr_done |=> ~address_error_trap)
    else $error("trap before instruction end");
  a_keep_high: assert property (@(posedge clk) disable iff (rst)
    (ext_op == msad_pkg::MSAD_EXT_NONE) & rd_en & rd_is_byte
    |=> wreg_result[15:8] == $past(wreg_value[15:8]))
    else $error("byte load changed high byte");
  a_sign_fill: assert property (@(posedge clk) disable iff (rst)
    ext_op == msad_pkg::MSAD_EXT_SIGN |=> wreg_result ==
    {{8{$past(wreg_value[7])}}, $past(wreg_value[7:0])})
    else $error("sign extend wrong");
  // Covers for the main scenarios.
  c_trap: cover property (@(posedge clk) address_error_trap);
  c_byte_wr: cover property (@(posedge clk) mem_byte_we == 2'b10);
  c_table: cover property (@(posedge clk)
    table_op & table_page_pointer[msad_pkg::TABLE_PAGE_TOP_BIT]);
  c_misalign_wr: cover property (@(posedge clk)
    wr_en & ~wr_is_byte & wr_effective_address[0]);
  c_window_rd: cover property (@(posedge clk)
    rd_en & rd_effective_address[15]);
endmodule
`default_nettype wire

// ==== tb/msad_mem_model.sv ====
// Data memory and register model that answers the decode block's reads.
`default_nettype none
module msad_mem_model (
  input wire logic clk,
  input wire logic [15:0] rd_effective_address,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] mem_byte_we,
  output logic [15:0] rd_mem_word,
  output logic rd_sfr_hit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem_reg [0:15];

  // Sixteen words alias across the space, so upper address bits are ignored.
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_reg[i] = {4'hA, i[3:0], 4'h5, i[3:0]};
    end
  end

  // Each lane is written only under its own strobe.
  always @(posedge clk) begin
    if (mem_byte_we[0]) begin
      mem_reg[mem_addr[4:1]][7:0] <= mem_wdata[7:0];
    end
    if (mem_byte_we[1]) begin
      mem_reg[mem_addr[4:1]][15:8] <= mem_wdata[15:8];
    end
  end

  // Only registers below 0x0040 exist; the rest of that area is a hole.
  assign rd_mem_word = mem_reg[rd_effective_address[4:1]];
  assign rd_sfr_hit = (rd_effective_address < 16'h0040);
endmodule
`default_nettype wire

// ==== tb/tb_memory_space_address_decode.sv ====
// Self-checking testbench for the memory space decode block.
`default_nettype none
module tb_memory_space_address_decode;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst, pc_step_fwd, pc_step_back, pc_load, table_op, instr_done;
  logic rd_en, rd_is_byte, wr_en, wr_is_byte, rd_sfr_hit;
  logic [22:0] pc_load_value;
  logic [7:0] table_page_pointer;
  logic [15:0] table_offset, rd_effective_address, wr_effective_address;
  logic [15:0] wr_data, wreg_value, rd_mem_word, rd_data, rd_ptr_incr;
  logic [15:0] mem_addr, mem_wdata, wr_ptr_incr, wreg_result;
  logic [1:0] ext_op, mem_byte_we;
  logic [23:0] prog_addr;
  logic prog_upper_word, prog_in_vectors, prog_access_fault;
  logic rd_program_window_view, address_error_trap;
  int fails = 0;
  int comparisons = 0;
  int ntrap = 0;

  msad_top u_msad_top (.clk, .rst, .pc_step_fwd, .pc_step_back, .pc_load,
    .pc_load_value, .table_op, .table_page_pointer, .table_offset,
    .prog_addr, .prog_upper_word, .prog_in_vectors, .prog_access_fault,
    .rd_en, .rd_effective_address, .rd_is_byte, .rd_mem_word, .rd_sfr_hit,
    .rd_data, .rd_program_window_view, .rd_ptr_incr, .wr_en,
    .wr_effective_address, .wr_is_byte, .wr_data, .mem_addr, .mem_wdata,
    .mem_byte_we, .wr_ptr_incr, .instr_done, .address_error_trap,
    .wreg_value, .ext_op, .wreg_result);
  msad_mem_model u_msad_mem_model (.clk, .rd_effective_address, .mem_addr,
    .mem_wdata, .mem_byte_we, .rd_mem_word, .rd_sfr_hit);

  // Clock and a running count of trap pulses, which last one cycle only.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (address_error_trap === 1'b1) begin
      ntrap++;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] ew(input logic [15:0] adr);
    ew = {4'hA, adr[4:1], 4'h5, adr[4:1]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs settle over several cycles so either counter latency is fine.
  task automatic prog(input logic [23:0] a, input logic up, input logic vec);
    cyc(3);
    chk(prog_addr, a);
    chk(24'(prog_upper_word), 24'(up));
    chk(24'(prog_in_vectors), 24'(vec));
    chk(24'(prog_access_fault), 24'h0);
  endtask

  task automatic rd(input logic [15:0] adr, input logic byt);
    rd_en = 1'b1;
    rd_effective_address = adr;
    rd_is_byte = byt;
    cyc(1);
    rd_en = 1'b0;
    cyc(1);
  endtask

  // Leaves the request up so that calls in a row run back to back.
  task automatic wr(input logic [15:0] adr, input logic byt,
    input logic [15:0] d, input logic [15:0] a, input logic [1:0] we,
    input logic [15:0] wd);
    wr_en = 1'b1;
    wr_effective_address = adr;
    wr_is_byte = byt;
    wr_data = d;
    cyc(1);
    chk(24'(mem_addr), 24'(a));
    chk(24'(mem_byte_we), 24'(we));
    chk(24'(mem_wdata), 24'(wd));
    chk(24'(wr_ptr_incr), byt ? 24'h1 : 24'h2);
  endtask

  task automatic done_pulse(input int exp_traps);
    int n0;
    n0 = ntrap;
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    cyc(4);
    chk(24'(ntrap - n0), 24'(exp_traps));
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_prog();
    prog(24'h00_0000, 1'b0, 1'b1);
    pc_load = 1'b1;
    pc_load_value = 23'h00_01FF;
    cyc(1);
    pc_load = 1'b0;
    prog(24'h00_01FE, 1'b0, 1'b1);
    pc_step_fwd = 1'b1;
    cyc(1);
    pc_step_fwd = 1'b0;
    prog(24'h00_0200, 1'b0, 1'b0);
    pc_step_back = 1'b1;
    cyc(1);
    pc_step_back = 1'b0;
    prog(24'h00_01FE, 1'b0, 1'b1);
    pc_load = 1'b1;
    pc_load_value = 23'h7F_FFFE;
    cyc(1);
    pc_load = 1'b0;
    prog(24'h7F_FFFE, 1'b0, 1'b0);
  endtask

  task automatic t_table();
    table_op = 1'b1;
    table_page_pointer = 8'h80;
    table_offset = 16'h0003;
    prog(24'h80_0003, 1'b1, 1'b0);
    table_page_pointer = 8'h00;
    table_offset = 16'h0100;
    prog(24'h00_0100, 1'b0, 1'b1);
    table_op = 1'b0;
    prog(24'h7F_FFFE, 1'b0, 1'b0);
  endtask

  task automatic t_reads();
    rd(16'h0810, 1'b0);
    chk(24'(rd_data), 24'(ew(16'h0810)));
    chk(24'(rd_ptr_incr), 24'h2);
    rd(16'h0811, 1'b1);
    chk(24'(rd_data[7:0]), 24'(ew(16'h0810) >> 8));
    chk(24'(rd_ptr_incr), 24'h1);
    rd(16'h0810, 1'b1);
    chk(24'(rd_data[7:0]), 24'(ew(16'h0810) & 16'h00FF));
    rd(16'h77FE, 1'b0);
    chk(24'(rd_data), 24'(ew(16'h77FE)));
    rd(16'h7800, 1'b0);
    chk(24'(rd_data), 24'h0);
    rd(16'h8000, 1'b0);
    chk(24'(rd_data), 24'h0);
    chk(24'(rd_program_window_view), 24'h1);
    rd(16'h0400, 1'b0);
    chk(24'(rd_data), 24'h0);
    chk(24'(rd_program_window_view), 24'h0);
    rd(16'h0004, 1'b0);
    chk(24'(rd_data), 24'(ew(16'h0004)));
  endtask

  task automatic t_writes();
    wr(16'h0811, 1'b1, 16'h0055, 16'h0810, 2'b10, 16'h5555);
    wr(16'h0814, 1'b1, 16'h00C3, 16'h0814, 2'b01, 16'hC3C3);
    rd_en = 1'b1;
    rd_effective_address = 16'h0812;
    rd_is_byte = 1'b0;
    wr(16'h0816, 1'b0, 16'h1234, 16'h0816, 2'b11, 16'h1234);
    rd_en = 1'b0;
    wr_en = 1'b0;
    chk(24'(rd_data), 24'(ew(16'h0812)));
    cyc(1);
    rd(16'h0810, 1'b0);
    chk(24'(rd_data), 24'h5558);
    rd(16'h0814, 1'b0);
    chk(24'(rd_data), 24'hAAC3);
    rd(16'h0816, 1'b0);
    chk(24'(rd_data), 24'h1234);
  endtask

  task automatic t_misalign();
    int n0;
    n0 = ntrap;
    rd(16'h0813, 1'b0);
    chk(24'(ntrap - n0), 24'h0);
    chk(24'(rd_data), 24'(ew(16'h0812)));
    done_pulse(1);
    wr(16'h0813, 1'b0, 16'h1234, 16'h0812, 2'b00, 16'h1234);
    wr_en = 1'b0;
    done_pulse(1);
    rd(16'h0812, 1'b0);
    chk(24'(rd_data), 24'(ew(16'h0812)));
    rd(16'h0813, 1'b1);
    done_pulse(0);
    // A fault in the finishing cycle traps at once.
    n0 = ntrap;
    rd_en = 1'b1;
    rd_effective_address = 16'h0815;
    rd_is_byte = 1'b0;
    instr_done = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    instr_done = 1'b0;
    cyc(2);
    chk(24'(ntrap - n0), 24'h1);
  endtask

  task automatic t_ext();
    wreg_value = 16'h3C85;
    ext_op = msad_pkg::MSAD_EXT_SIGN;
    cyc(1);
    chk(24'(wreg_result), 24'hFF85);
    ext_op = msad_pkg::MSAD_EXT_ZERO;
    cyc(1);
    chk(24'(wreg_result), 24'h0085);
    ext_op = msad_pkg::MSAD_EXT_NONE;
    rd_en = 1'b1;
    rd_effective_address = 16'h0005;
    rd_is_byte = 1'b1;
    cyc(1);
    chk(24'(wreg_result), 24'h3CA2);
    rd_en = 1'b0;
  endtask

  // A reset in mid-run sends fetch back to zero, sets the vector flag and clears read data and write step.
  task automatic t_reset();
    pc_load = 1'b1;
    pc_load_value = 23'h00_0400;
    cyc(1);
    pc_load = 1'b0;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk(prog_addr, 24'h00_0000);
    chk(24'(prog_in_vectors), 24'h1);
    chk(24'(rd_data), 24'h0);
    chk(24'(wr_ptr_incr), 24'h0);
  endtask

  // ----------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {pc_step_fwd, pc_step_back, pc_load, table_op, instr_done} = '0;
    {rd_en, rd_is_byte, wr_en, wr_is_byte, ext_op} = '0;
    {pc_load_value, table_page_pointer, table_offset} = '0;
    {rd_effective_address, wr_effective_address, wr_data, wreg_value} = '0;
    cyc(10);
    rst = 1'b0;
    cyc(1);
    chk(24'(mem_byte_we), 24'h0);
    t_prog();
    t_table();
    t_reads();
    t_writes();
    t_misalign();
    t_ext();
    t_reset();
    results();
  end

  // The tests need about a hundred cycles; this margin covers any stall.
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    $display("Error at %0t ns: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
